// >>> fps_sequencer.sv
// Flyback controller sequencing, PWM, protections and register slave
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE1] Setpoint equals feedback divided by five
// [RULE2] Falling slope subtracted during each on-time
// [RULE3] Overload timer starts at limit demand
// [RULE4] Timer expiry stops gate, latch or restart
// [RULE5] Timer clears when demand drops below limit
// [RULE6] No timer start on max-duty terminated cycles
// [RULE7] Auto mode retries after restart delay
// [RULE8] Latched overload held until brown-out or reset
// [RULE9] Period stretches linearly below foldback start
// [RULE10] Peak current regulation stays active in foldback
// [RULE11] Foldback inhibited at maximum duty
// [RULE12] Skip entry halts gate, lowers consumption
// [RULE13] Skip held until feedback passes exit level
// [RULE14] Latch input outside window latches off
// [RULE15] Latch excursions shorter than blanking ignored
// [RULE16] Latch-input shutdown cleared only by supply reset
// [RULE17] Latch ignored until start; high checked first
// [RULE18] Low latch checked only after soft-start
// [RULE19] Thermistor bias doubled during soft-start
// [RULE20] Thermal trip stops switching, resets logic
// [RULE21] Thermal clear re-enables startup, normal start
// [RULE22] Soft-start ramp in fifteen steps
// [RULE23] Stop-level current enters protection at once
// [RULE24] Supply stop halts and clears overload timer
// [RULE25] Durations are cycle counts from parameters
module fps_sequencer
    import fps_pkg::*;
#(
    parameter bit AUTO_RECOVERY = 1'b0,   // Overload option after reset
    parameter bit HIGH_RATE     = 1'b0,   // Rate option select
    parameter int FAULT_US      = 128000, // Overload timeout
    parameter int RESTART_US    = 1000000,// Auto restart delay
    parameter int SS_US         = 4000,   // Soft-start duration
    parameter int HI_BLANK_US   = 50,     // High latch blanking
    parameter int LO_BLANK_US   = 350,    // Low latch blanking
    parameter int FOLD_START_MV = 1500,   // Foldback start level
    parameter int SKIP_IN_MV    = 400,    // Skip entry level
    parameter int SKIP_OUT_MV   = 450,    // Skip exit level
    parameter int MIN_RATE_KHZ  = 25      // Slowest switching rate
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire fps_pins_t   pins,
    input  wire logic [11:0] feedback_input,
    input  wire logic [11:0] cs_sense_mv,
    output logic             gate_drive_output,
    output logic             high_voltage_startup_pin,
    output logic             boosted_thermistor_bias,
    output logic             low_power_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Derived cycle counts
    localparam logic [31:0] FAULT_CYC   = 32'(FAULT_US * CLK_MHZ);     // [RULE25]
    localparam logic [31:0] RESTART_CYC = 32'(RESTART_US * CLK_MHZ);   // [RULE25]
    localparam logic [31:0] STEP_CYC    = 32'(SS_US * CLK_MHZ / SS_STEPS);
    localparam logic [31:0] HI_CYC      = 32'(HI_BLANK_US * CLK_MHZ); // [RULE25]
    localparam logic [31:0] LO_CYC      = 32'(LO_BLANK_US * CLK_MHZ);
    localparam logic [15:0] NOM_PER     = 16'(CLK_MHZ * KHZ_PER_MHZ / (HIGH_RATE ? RATE_HI_KHZ : RATE_LO_KHZ));
    localparam logic [15:0] MAX_PER     = 16'(CLK_MHZ * KHZ_PER_MHZ / MIN_RATE_KHZ);
    localparam logic [23:0] SLOPE_CYC   = 24'((HIGH_RATE ? SLOPE_HI_UV_US : SLOPE_LO_UV_US) / CLK_MHZ);
    localparam logic [23:0] LIM_UV      = 24'(LIMIT_UV);
    localparam logic [3:0]  LAST_STEP   = 4'(SS_STEPS);

    // Refuse settings the logic cannot serve
    if (SKIP_OUT_MV <= SKIP_IN_MV || FOLD_START_MV <= SKIP_OUT_MV || MAX_PER <= NOM_PER
        || STEP_CYC == 32'h0 || HI_CYC == 32'h0 || LO_CYC == 32'h0) begin : g_bad
        $error("fps_sequencer: inconsistent levels or durations");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages with agreement filter
    logic [PIN_W-1:0] s1_ff, s2_ff, s3_ff;  // Synchroniser chain
    logic [PIN_W-1:0] pin_ff, nxt_pin;      // Filtered pin levels
    fps_pins_t        pv;                   // Filtered pins by name

    // Next filtered level follows stage three when two and three agree
    always_comb begin
        nxt_pin = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & pin_ff);
    end

    // Chain and filter registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            pin_ff <= '0;
        end else begin
            s1_ff  <= pins;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    assign pv = fps_pins_t'(pin_ff);

    ////////////////////////////////////////////////////////////////////////
    // Register slave state
    logic [1:0]  ctrl_ff, nxt_ctrl;   // Run enable and auto-recovery select
    logic        ack_ff, nxt_ack;     // Bus acknowledge
    logic [31:0] dat_ff, nxt_dat;     // Read data
    logic        run_en, auto_en;     // Decoded control bits

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    fps_state_t  state_ff, nxt_state; // Controller state
    logic [31:0] tmr_ff, nxt_tmr;     // Soft-start step or restart timer
    logic [31:0] ovl_ff, nxt_ovl;     // Overload timer
    logic [31:0] hi_ff, nxt_hi;       // High latch blanking counter
    logic [31:0] lo_ff, nxt_lo;       // Low latch blanking counter
    logic [15:0] phase_ff, nxt_phase; // Position inside switching period
    logic [15:0] period_ff, nxt_period; // Current switching period
    logic [3:0]  step_ff, nxt_step;   // Soft-start step
    logic        gate_ff, nxt_gate;   // Gate drive
    logic        maxd_ff, nxt_maxd;   // Last pulse ended by duty limit
    logic        skip_ff, nxt_skip;   // Skip mode
    logic        hv_ff, bias_ff, lp_ff; // Registered side outputs

    // Analog terms
    logic [23:0] demand_uv, ss_uv, base_uv, ramp_uv, set_uv, cs_uv;
    logic [31:0] fold_num, max_on;
    logic [15:0] fold_per;
    logic        at_limit, cs_stop, switching, protect, hi_trip, lo_trip;

    assign run_en  = ctrl_ff[CTRL_RUN_BIT];
    assign auto_en = ctrl_ff[CTRL_AUTO_BIT];

    // Setpoint, slope and foldback arithmetic
    always_comb begin
        demand_uv = 24'(32'(feedback_input) * UV_PER_MV / FB_RATIO);           // [RULE1]
        ss_uv     = (state_ff == ST_SOFT) ? 24'((32'(LIM_UV) * step_ff) / SS_STEPS) : LIM_UV; // [RULE22]
        base_uv   = (demand_uv < LIM_UV) ? demand_uv : LIM_UV;
        base_uv   = (ss_uv < base_uv) ? ss_uv : base_uv;
        ramp_uv   = 24'(32'(phase_ff) * SLOPE_CYC);                             // [RULE2]
        set_uv    = (base_uv > ramp_uv) ? base_uv - ramp_uv : 24'h0;            // [RULE2]
        cs_uv     = 24'(32'(cs_sense_mv) * UV_PER_MV);
        at_limit  = demand_uv >= LIM_UV;                                        // [RULE3]
        cs_stop   = 32'(cs_uv) * STOP_DEN >= 32'(LIM_UV) * STOP_NUM;            // [RULE23]
        fold_num  = 32'(FOLD_START_MV) - 32'(feedback_input);
        if (maxd_ff || 32'(feedback_input) >= 32'(FOLD_START_MV)) begin
            fold_per = NOM_PER;                                                 // [RULE11]
        end else if (32'(feedback_input) <= 32'(SKIP_OUT_MV)) begin
            fold_per = MAX_PER;                                                 // [RULE9]
        end else begin
            fold_per = NOM_PER + 16'(fold_num * 32'(MAX_PER - NOM_PER)
                       / 32'(FOLD_START_MV - SKIP_OUT_MV));                     // [RULE9]
        end
        max_on    = 32'(period_ff) * MAX_DUTY_PCT / PCT_FULL;
        switching = (state_ff == ST_SOFT) || (state_ff == ST_RUN);
        hi_trip   = pv.latch_high && (hi_ff >= HI_CYC - 32'h1);                 // [RULE15]
        lo_trip   = pv.latch_low && (lo_ff >= LO_CYC - 32'h1);                  // [RULE15]
        protect   = cs_stop || (ovl_ff >= FAULT_CYC - 32'h1);                   // [RULE23]
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        nxt_state  = state_ff;
        nxt_tmr    = tmr_ff;
        nxt_ovl    = ovl_ff;
        nxt_phase  = phase_ff;
        nxt_period = period_ff;
        nxt_step   = step_ff;
        nxt_gate   = gate_ff;
        nxt_maxd   = maxd_ff;
        // Skip hysteresis between entry and exit levels
        if (32'(feedback_input) <= 32'(SKIP_IN_MV)) begin
            nxt_skip = 1'b1;                                                    // [RULE12]
        end else if (32'(feedback_input) > 32'(SKIP_OUT_MV)) begin
            nxt_skip = 1'b0;                                                    // [RULE13]
        end else begin
            nxt_skip = skip_ff;                                                 // [RULE13]
        end
        // High latch watched from start onward, low latch after soft-start
        nxt_hi = (pv.latch_high && state_ff inside {ST_SOFT, ST_RUN, ST_WAIT}) ? hi_ff + 32'h1 : 32'h0; // [RULE17]
        nxt_lo = (pv.latch_low && state_ff == ST_RUN) ? lo_ff + 32'h1 : 32'h0; // [RULE18]
        case (state_ff)
            ST_OFF: begin
                nxt_gate  = 1'b0;
                nxt_ovl   = 32'h0;
                nxt_tmr   = 32'h0;
                nxt_step  = 4'h0;
                nxt_phase = 16'h0;
                // Start only when high latch does not forbid it
                if (pv.supply_start_threshold && !pv.latch_high) begin
                    nxt_state = ST_SOFT;                                        // [RULE17]
                end
            end
            ST_SOFT, ST_RUN: begin
                // Period boundary: reload period and fire a pulse
                if (phase_ff >= period_ff - 16'h1) begin
                    nxt_phase  = 16'h0;
                    nxt_period = fold_per;                                      // [RULE9]
                    nxt_gate   = run_en && !skip_ff;                            // [RULE12]
                end else begin
                    nxt_phase = phase_ff + 16'h1;
                    // Peak current ends the pulse in every rate
                    if (gate_ff && cs_uv >= set_uv) begin
                        nxt_gate = 1'b0;                                        // [RULE10]
                        nxt_maxd = 1'b0;
                    end else if (gate_ff && 32'(phase_ff) + 32'h1 >= max_on) begin
                        nxt_gate = 1'b0;
                        nxt_maxd = 1'b1;
                    end
                end
                // Overload timer runs while demand is at limit and the last pulse was not ended by the duty limit
                nxt_ovl = (at_limit && !maxd_ff) ? ovl_ff + 32'h1 : 32'h0;      // [RULE3] [RULE5] [RULE6]
                // Soft-start staircase
                if (state_ff == ST_SOFT) begin
                    if (tmr_ff >= STEP_CYC - 32'h1) begin
                        nxt_tmr = 32'h0;
                        if (step_ff == LAST_STEP) begin
                            nxt_state = ST_RUN;                                 // [RULE22]
                        end else begin
                            nxt_step = step_ff + 4'h1;                          // [RULE22]
                        end
                    end else begin
                        nxt_tmr = tmr_ff + 32'h1;
                    end
                end
                // Overload or stop-level current: protection
                if (protect) begin
                    nxt_gate  = 1'b0;                                           // [RULE4]
                    nxt_ovl   = 32'h0;
                    nxt_tmr   = 32'h0;
                    nxt_phase = 16'h0;
                    nxt_state = auto_en ? ST_WAIT : ST_LOCK_OVL;                // [RULE4] [RULE23]
                end
            end
            ST_WAIT: begin
                nxt_gate = 1'b0;
                // Retry through a fresh soft-start after the delay
                if (tmr_ff >= RESTART_CYC - 32'h1) begin
                    nxt_tmr   = 32'h0;
                    nxt_step  = 4'h0;
                    nxt_state = ST_SOFT;                                        // [RULE7]
                end else begin
                    nxt_tmr = tmr_ff + 32'h1;
                end
            end
            ST_LOCK_OVL: begin
                nxt_gate = 1'b0;
                if (pv.brown_out || pv.supply_reset_level) begin
                    nxt_state = ST_OFF;                                         // [RULE8]
                end
            end
            ST_LOCK_PIN: begin
                nxt_gate = 1'b0;
                if (pv.supply_reset_level) begin
                    nxt_state = ST_OFF;                                         // [RULE16]
                end
            end
            ST_THERMAL: begin
                nxt_gate = 1'b0;
                if (!pv.thermal_trip) begin
                    nxt_state = ST_OFF;                                         // [RULE21]
                end
            end
            default: begin
                nxt_gate  = 1'b0;
                nxt_state = ST_OFF;
            end
        endcase
        // Latch input window violated long enough
        if ((hi_trip || lo_trip) && state_ff inside {ST_SOFT, ST_RUN, ST_WAIT}) begin
            nxt_gate  = 1'b0;
            nxt_state = ST_LOCK_PIN;                                            // [RULE14]
        end
        // Supply at stop level ends operation
        if (pv.supply_stop_threshold && state_ff inside {ST_SOFT, ST_RUN, ST_WAIT}) begin
            nxt_gate  = 1'b0;
            nxt_ovl   = 32'h0;                                                  // [RULE24]
            nxt_state = ST_OFF;                                                 // [RULE24]
        end
        // Thermal trip overrides everything and clears the logic
        if (pv.thermal_trip) begin
            nxt_state  = ST_THERMAL;                                            // [RULE20]
            nxt_gate   = 1'b0;
            nxt_ovl    = 32'h0;
            nxt_tmr    = 32'h0;
            nxt_hi     = 32'h0;
            nxt_lo     = 32'h0;
            nxt_step   = 4'h0;
            nxt_phase  = 16'h0;
            nxt_maxd   = 1'b0;
            nxt_period = NOM_PER;
        end
    end

    // Sequencer registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff  <= ST_OFF;
            tmr_ff    <= 32'h0;
            ovl_ff    <= 32'h0;
            hi_ff     <= 32'h0;
            lo_ff     <= 32'h0;
            phase_ff  <= 16'h0;
            period_ff <= NOM_PER;
            step_ff   <= 4'h0;
            gate_ff   <= 1'b0;
            maxd_ff   <= 1'b0;
            skip_ff   <= 1'b0;
            hv_ff     <= 1'b1;
            bias_ff   <= 1'b0;
            lp_ff     <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            tmr_ff    <= nxt_tmr;
            ovl_ff    <= nxt_ovl;
            hi_ff     <= nxt_hi;
            lo_ff     <= nxt_lo;
            phase_ff  <= nxt_phase;
            period_ff <= nxt_period;
            step_ff   <= nxt_step;
            gate_ff   <= nxt_gate;
            maxd_ff   <= nxt_maxd;
            skip_ff   <= nxt_skip;
            hv_ff     <= nxt_state != ST_THERMAL;                               // [RULE20] [RULE21]
            bias_ff   <= nxt_state == ST_SOFT;                                  // [RULE19]
            lp_ff     <= nxt_skip && (nxt_state == ST_RUN || nxt_state == ST_SOFT); // [RULE12]
        end
    end

    assign gate_drive_output        = gate_ff;
    assign high_voltage_startup_pin = hv_ff;
    assign boosted_thermistor_bias  = bias_ff;
    assign low_power_mode           = lp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, unmapped reads return zero
    always_comb begin
        nxt_ack  = wb_cyc_i && wb_stb_i && !ack_ff;
        nxt_ctrl = ctrl_ff;
        nxt_dat  = dat_ff;
        // Write lands on the acknowledging edge
        if (wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
            nxt_ctrl = wb_dat_i[1:0];
        end
        // Read data captured with the request
        if (nxt_ack) begin
            case (wb_adr_i)
                REG_CTRL:   nxt_dat = {30'h0, ctrl_ff};
                REG_STATUS: nxt_dat = {24'h0, hv_ff, maxd_ff, gate_ff, skip_ff, 1'b0, state_ff};
                REG_PERIOD: nxt_dat = {16'h0, period_ff};
                default:    nxt_dat = 32'h0;
            endcase
        end
    end

    // Slave registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= {AUTO_RECOVERY, 1'b1};
            ack_ff  <= 1'b0;
            dat_ff  <= 32'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            ack_ff  <= nxt_ack;
            dat_ff  <= nxt_dat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_thermal_stop: assert property (pv.thermal_trip |=> state_ff == ST_THERMAL && !gate_ff && !hv_ff) // [RULE20]
        else $error("thermal trip did not stop the controller");
    chk_thermal_back: assert property (state_ff == ST_THERMAL && !pv.thermal_trip
        |=> state_ff == ST_OFF ##1 hv_ff) // [RULE21]
        else $error("thermal release did not restart");
    chk_skip_gate: assert property ($rose(gate_ff) |-> $past(!skip_ff) && $past(run_en)) // [RULE12]
        else $error("pulse started in skip mode");
    chk_ovl_clear: assert property (switching && !at_limit && !pv.thermal_trip |=> ovl_ff == 32'h0) // [RULE5]
        else $error("overload timer not cleared");
    chk_fault_off: assert property (state_ff inside {ST_WAIT, ST_LOCK_OVL, ST_LOCK_PIN} |-> !gate_ff) // [RULE4]
        else $error("gate active during protection");
    chk_lock_hold: assert property (state_ff == ST_LOCK_OVL && !pv.brown_out && !pv.supply_reset_level
        && !pv.thermal_trip |=> state_ff == ST_LOCK_OVL) // [RULE8]
        else $error("overload latch released early");
    chk_pin_hold: assert property (state_ff == ST_LOCK_PIN && !pv.supply_reset_level
        && !pv.thermal_trip |=> state_ff == ST_LOCK_PIN) // [RULE16]
        else $error("latch input shutdown released early");
    chk_supply_stop: assert property (pv.supply_stop_threshold && !pv.thermal_trip
        && state_ff inside {ST_SOFT, ST_RUN, ST_WAIT} |=> state_ff == ST_OFF && ovl_ff == 32'h0) // [RULE24]
        else $error("supply stop ignored");
    chk_stop_level: assert property (switching && cs_stop && !pv.thermal_trip && !pv.supply_stop_threshold
        && !hi_trip && !lo_trip |=> state_ff inside {ST_WAIT, ST_LOCK_OVL}) // [RULE23]
        else $error("stop-level current not acted on");

    cov_skip: cover property (state_ff == ST_RUN && $rose(skip_ff));
    cov_retry: cover property (state_ff == ST_WAIT ##1 state_ff == ST_SOFT);
    cov_pin_lock: cover property ($rose(state_ff == ST_LOCK_PIN));

endmodule

`default_nettype wire

// >>> fps_pkg.sv
// Package with constants, states and pin bundle of the flyback protection sequencer
package fps_pkg;

    // Clock and analog scaling
    localparam int CLK_MHZ        = 100;      // mclk rate in MHz
    localparam int UV_PER_MV      = 1000;     // Microvolts per millivolt
    localparam int FB_RATIO       = 5;        // Feedback to setpoint divider
    localparam int LIMIT_FB_MV    = 3500;     // Feedback level matching the limit
    localparam int LIMIT_UV       = LIMIT_FB_MV * UV_PER_MV / FB_RATIO;
    localparam int STOP_NUM       = 3;        // Stop level is 1.5 times the limit
    localparam int STOP_DEN       = 2;

    // Slope compensation, in uV per us, per rate option
    localparam int SLOPE_LO_UV_US = 32500;
    localparam int SLOPE_HI_UV_US = 50000;

    // Switching rates and duty limit
    localparam int RATE_LO_KHZ    = 65;
    localparam int RATE_HI_KHZ    = 100;
    localparam int KHZ_PER_MHZ    = 1000;
    localparam int MAX_DUTY_PCT   = 80;
    localparam int PCT_FULL       = 100;

    // Soft-start ramp resolution
    localparam int SS_STEPS       = 15;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PERIOD = 8'h08;

    // Control and status fields
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_AUTO_BIT  = 1;
    localparam int STAT_SKIP_BIT  = 4;
    localparam int STAT_GATE_BIT  = 5;
    localparam int STAT_MAXD_BIT  = 6;
    localparam int STAT_HV_BIT    = 7;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF, ST_SOFT, ST_RUN, ST_WAIT, ST_LOCK_OVL, ST_LOCK_PIN, ST_THERMAL
    } fps_state_t;

    // Comparator and supervisor pins, all asynchronous
    typedef struct packed {
        logic supply_start_threshold;  // Supply above start level
        logic supply_stop_threshold;   // Supply at stop level
        logic supply_reset_level;      // Supply cycled down to reset level
        logic brown_out;               // Line brown-out detected
        logic thermal_trip;            // Die over temperature
        logic latch_high;              // Latch input above high threshold
        logic latch_low;               // Latch input below low threshold
    } fps_pins_t;

    localparam int PIN_W = $bits(fps_pins_t);

endpackage

// >>> fps_switch_model.sv
// Behavioural power switch with sense resistor, driven by the gate output
`timescale 1ns/1ps
`default_nettype none
module fps_switch_model (
    input  wire logic        mclk,
    input  wire logic        gate_drive_output,
    input  wire logic        winding_short,
    output logic      [11:0] cs_sense_mv
);
    // Sense ramps 20 mV per cycle while the switch conducts and collapses when it opens;
    // a shorted winding pins the sense at full scale, far above the stop level
    always_ff @(posedge mclk) begin
        cs_sense_mv <= winding_short ? 12'hFFF : (gate_drive_output ? cs_sense_mv + 12'h014 : 12'h000);
    end
endmodule
`default_nettype wire

// >>> tb_fps_sequencer.sv
// Self-checking bench: start-up, skip, overload options, latch pin, thermal trip
`timescale 1ns/1ps
`default_nettype none
module tb_fps_sequencer;
    import fps_pkg::*;
    logic        mclk, rst, cyc, stb, we, ack, gate, hv, bias, lpm, wshort;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, rd;
    logic [11:0] fb, cs;
    fps_pins_t   pins;
    int          errors, checks, i;
    fps_sequencer #(.FAULT_US(2), .RESTART_US(3), .SS_US(3), .HI_BLANK_US(1), .LO_BLANK_US(2)) DUT (
        .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pins(pins),
        .feedback_input(fb), .cs_sense_mv(cs), .gate_drive_output(gate),
        .high_voltage_startup_pin(hv), .boosted_thermistor_bias(bias), .low_power_mode(lpm));
    fps_switch_model SW (.mclk(mclk), .gate_drive_output(gate), .winding_short(wshort), .cs_sense_mv(cs));
    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Compare one value and count the outcome
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic Wishbone single cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        @(posedge mclk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        rd = rdat;
        {cyc, stb, we} <= 3'h0;
    endtask
    // Poll the state field until it matches
    task automatic wait_st(input logic [2:0] s);
        rd = 32'hFFFF_FFFF;
        for (int n = 0; n < 600 && rd[2:0] !== s; n++) bus(1'b0, REG_STATUS, 32'h0);
        chk(rd & 32'h7, {29'h0, s});
    endtask
    task automatic give_verdict;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog at about five times the expected run of some 4000 cycles
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    initial begin
        {cyc, stb, we, adr, wdat, sel, wshort, pins, errors, checks} = '0;
        rst = 1'b1;
        fb = 12'h7DA;                                  // 2010 mV, off the 100 mV grid
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        bus(1'b0, REG_CTRL, 32'h0); chk(rd, 32'h1);
        bus(1'b0, 8'h0C, 32'h0); chk(rd, 32'h0);
        bus(1'b0, REG_PERIOD, 32'h0); chk(rd, 32'h602);
        pins.supply_start_threshold <= 1'b1;
        wait_st(3'h1);
        chk({31'h0, bias}, 32'h1);
        wait_st(3'h2);
        chk({31'h0, bias}, 32'h0);
        // First pulse ends when 20 mV steps meet 402 mV less 0.325 mV per cycle: 21 cycles
        for (i = 0; i < 2000 && gate !== 1'b1; i++) @(posedge mclk);
        for (i = 0; i < 100 && gate === 1'b1; i++) @(posedge mclk);
        chk(i, 32'h15);
        fb <= 12'd300;
        for (i = 0; i < 4000 && lpm !== 1'b1; i++) @(posedge mclk);
        chk({30'h0, lpm, gate}, 32'h2);
        fb <= 12'd600;
        for (i = 0; i < 4000 && lpm !== 1'b0; i++) @(posedge mclk);
        chk({31'h0, lpm}, 32'h0);
        fb <= 12'd3600;
        wait_st(3'h4);
        chk({31'h0, gate}, 32'h0);
        pins <= '{brown_out: 1'b1, default: 1'b0};
        wait_st(3'h0);
        bus(1'b1, REG_CTRL, 32'h3);
        bus(1'b0, REG_CTRL, 32'h0); chk(rd, 32'h3);
        bus(1'b1, REG_CTRL, 32'h0, 4'h0);
        bus(1'b0, REG_CTRL, 32'h0); chk(rd, 32'h3);
        pins <= '{supply_start_threshold: 1'b1, default: 1'b0};
        wait_st(3'h3);
        wait_st(3'h1);
        fb <= 12'd2000;
        wait_st(3'h2);
        wshort <= 1'b1;
        wait_st(3'h3);
        wshort <= 1'b0;
        wait_st(3'h2);
        pins.latch_high <= 1'b1;
        wait_st(3'h5);
        pins <= '{brown_out: 1'b1, default: 1'b0};
        repeat (20) @(posedge mclk);
        wait_st(3'h5);
        pins <= '{supply_reset_level: 1'b1, default: 1'b0};
        wait_st(3'h0);
        pins <= '{thermal_trip: 1'b1, default: 1'b0};
        wait_st(3'h6);
        chk({30'h0, hv, gate}, 32'h0);
        pins <= '0;
        wait_st(3'h0);
        repeat (2) @(posedge mclk);
        chk({31'h0, hv}, 32'h1);
        pins <= '{supply_start_threshold: 1'b1, latch_low: 1'b1, default: 1'b0};
        wait_st(3'h2);
        wait_st(3'h5);
        pins <= '{supply_reset_level: 1'b1, default: 1'b0};
        wait_st(3'h0);
        pins <= '{supply_start_threshold: 1'b1, default: 1'b0};
        wait_st(3'h1);
        pins <= '{supply_stop_threshold: 1'b1, default: 1'b0};
        wait_st(3'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
